//--- rtl/bmr_defs.svh
`ifndef BMR_DEFS_SVH
`define BMR_DEFS_SVH
// Code and data space windows
`define BMR_ROM_LO_BASE   16'h0000
`define BMR_ROM_LO_LAST   16'h17FF
`define BMR_ROM_HI_BASE   16'h8000
`define BMR_ROM_HI_LAST   16'h97FF
`define BMR_RAM_BASE      16'h0000
`define BMR_RAM_LAST      16'h1FFF
`define BMR_MMIO_BASE     16'hFD80
`define BMR_MMIO_LAST     16'hFFFF
`define BMR_RESET_VECTOR  16'h0000
// Register offsets
`define BMR_REG_MAP_CTL   4'h0
`define BMR_REG_USB_CTL   4'h1
`define BMR_REG_STATUS    4'h2
// Field positions
`define BMR_MAP_SWITCH_BIT  0
`define BMR_CONNECT_BIT     0
`define BMR_ST_SUSPEND_BIT  0
`define BMR_ST_SELF_PWR_BIT 1
`define BMR_ST_PORT3_3_BIT  2
// Reset values
`define BMR_MAP_RESET     1'b0
`define BMR_CONNECT_RESET 1'b0
// RAM geometry
`define BMR_RAM_AW        13
`endif

//--- rtl/bmr_pkg.sv
package bmr_pkg;
  typedef enum logic [1:0] {BMR_SEL_NONE, BMR_SEL_ROM, BMR_SEL_RAM, BMR_SEL_MMIO} bmr_sel_t;
  // Memory request from the core
  typedef struct packed {
    logic        code;
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bmr_req_t;
  // Decode outcome toward memories
  typedef struct packed {
    bmr_sel_t    sel;
    logic [15:0] offs;
    logic        wr_ok;
  } bmr_dec_t;
endpackage

//--- rtl/bmr_ram.sv
`timescale 1ns/10ps
`include "bmr_defs.svh"
module bmr_ram (
  input  wire logic                     ref_clk,
  input  wire logic                     we,
  input  wire logic [`BMR_RAM_AW-1:0]   addr,
  input  wire logic [7:0]               wdata,
  output logic      [7:0]               rdata
);
  logic [7:0] mem [0:(1<<`BMR_RAM_AW)-1];
  // Registered read, write through strobe
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- rtl/bmr_top.sv
`timescale 1ns/10ps
`include "bmr_defs.svh"
// Notes on behaviour
// [R1] Map bit zero: boot ROM in code at 0000-17FF and mirrored at 8000-97FF.
// [R2] Map bit zero: program RAM is data space 0000-1FFF, readable and writable.
// [R3] Map bit one: boot ROM only at code 8000-97FF.
// [R4] Map bit one: program RAM is code space 0000-1FFF.
// [R5] Data FD80-FFFF goes to buffers, registers and I/O in both modes.
// [R6] Reset clears map bit and connect bit: boot mode, detached.
// [R7] After reset the core fetches from address zero, inside boot ROM.
// [R8] Boot firmware loads RAM through data space from EEPROM or USB.
// [R9] Setting map bit switches to normal mode; execution restarts at zero in RAM.
// [R10] Setting connect bit after switch attaches device to the USB bus.
// [R11] Suspend indicator high while suspended, low otherwise.
// [R12] Board drives power select high for self-powered, low for bus-powered.
// [R13] Port 3 bit 3 never feeds external interrupt one.
// [R14] Master reset input resets core and map control state.
// [R15] Core may set map bit but never clear it.
// [R16] Normal mode blocks writes into RAM used as code.
// [R17] Pullup pin floats while connect bit is zero, driven when one.
module bmr_top
  import bmr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire bmr_req_t    mem_req,
  output logic      [7:0]  mem_rdata,
  output logic             mem_rvalid,
  input  wire logic [7:0]  rom_rdata,
  output logic      [15:0] rom_addr,
  output logic             rom_rd,
  output logic      [15:0] mmio_addr,
  output logic             mmio_wr,
  output logic             mmio_rd,
  output logic      [7:0]  mmio_wdata,
  input  wire logic [7:0]  mmio_rdata,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        usb_suspended,
  input  wire logic        self_powered,
  input  wire logic        port3_bit3,
  output logic             suspend_indicator,
  output logic             pullup_drive_pin_o,
  output logic             pullup_drive_pin_oe,
  output logic             core_rst_n,
  output logic      [15:0] core_restart_pc,
  output logic             core_restart,
  output logic             external_irq_one
);
  // ==========================================================
  // Reset synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;
  // [R14] Master reset source
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // ==========================================================
  // Control registers
  logic map_switch_bit_reg;
  logic map_switch_bit_next;
  logic bus_connect_bit_reg;
  logic bus_connect_bit_next;
  wire  wr_map = reg_wr && (reg_addr == `BMR_REG_MAP_CTL);
  wire  wr_usb = reg_wr && (reg_addr == `BMR_REG_USB_CTL);
  // [R15] Set only, never cleared by core
  assign map_switch_bit_next = map_switch_bit_reg |
                               (wr_map & reg_wdata[`BMR_MAP_SWITCH_BIT]);
  // Connect bit freely writable
  assign bus_connect_bit_next = wr_usb ? reg_wdata[`BMR_CONNECT_BIT] : bus_connect_bit_reg;
  // [R6] Reset clears both bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_switch_bit_reg  <= `BMR_MAP_RESET;
      bus_connect_bit_reg <= `BMR_CONNECT_RESET;
    end else begin
      map_switch_bit_reg  <= map_switch_bit_next;
      bus_connect_bit_reg <= bus_connect_bit_next;
    end
  end

  // ==========================================================
  // Register read port
  logic [7:0] reg_rdata_next;
  wire  [7:0] status_word = {5'h00, port3_bit3, self_powered, usb_suspended};
  // Unmapped offsets read as zero
  assign reg_rdata_next = !reg_rd ? 8'h00 :
                          (reg_addr == `BMR_REG_MAP_CTL) ? {7'h00, map_switch_bit_reg} :
                          (reg_addr == `BMR_REG_USB_CTL) ? {7'h00, bus_connect_bit_reg} :
                          (reg_addr == `BMR_REG_STATUS)  ? status_word : 8'h00;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rdata_next;
    end
  end

  // ==========================================================
  // Address decode
  wire [15:0] a       = mem_req.addr;
  wire        in_rlo  = (a >= `BMR_ROM_LO_BASE) && (a <= `BMR_ROM_LO_LAST);
  wire        in_rhi  = (a >= `BMR_ROM_HI_BASE) && (a <= `BMR_ROM_HI_LAST);
  wire        in_ram  = (a >= `BMR_RAM_BASE) && (a <= `BMR_RAM_LAST);
  wire        in_mmio = (a >= `BMR_MMIO_BASE) && (a <= `BMR_MMIO_LAST);
  wire        acc     = mem_req.rd | mem_req.wr;
  // [R1] Boot mode: ROM low and mirrored high
  wire        boot_rom = !map_switch_bit_reg && mem_req.code && (in_rlo || in_rhi);
  // [R3] Normal mode: ROM only high
  wire        norm_rom = map_switch_bit_reg && mem_req.code && in_rhi;
  // [R2] [R8] Boot mode: RAM in data space, loader writes here
  wire        data_ram = !map_switch_bit_reg && !mem_req.code && in_ram;
  // [R4] Normal mode: RAM in code space
  wire        code_ram = map_switch_bit_reg && mem_req.code && in_ram;
  // [R5] Top data window in both modes
  wire        sel_mmio = !mem_req.code && in_mmio;
  wire [15:0] rom_off  = in_rhi ? (a - `BMR_ROM_HI_BASE) : a;
  bmr_dec_t   dec;
  assign dec.sel   = (boot_rom || norm_rom) ? BMR_SEL_ROM :
                     (data_ram || code_ram) ? BMR_SEL_RAM :
                     sel_mmio ? BMR_SEL_MMIO : BMR_SEL_NONE;
  assign dec.offs  = (dec.sel == BMR_SEL_ROM) ? rom_off : a;
  // [R16] Code space is read-only
  assign dec.wr_ok = mem_req.wr && !mem_req.code && (dec.sel != BMR_SEL_NONE);

  // ==========================================================
  // Program RAM
  wire [7:0] ram_rdata;
  wire       ram_we = dec.wr_ok && (dec.sel == BMR_SEL_RAM);
  bmr_ram u_ram (
    .ref_clk (ref_clk),
    .we      (ram_we),
    .addr    (dec.offs[`BMR_RAM_AW-1:0]),
    .wdata   (mem_req.wdata),
    .rdata   (ram_rdata)
  );

  // ==========================================================
  // Outward strobes and read return
  bmr_sel_t sel_d_reg;
  logic     rd_d_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_addr   <= 16'h0000;
      rom_rd     <= 1'b0;
      mmio_addr  <= 16'h0000;
      mmio_wr    <= 1'b0;
      mmio_rd    <= 1'b0;
      mmio_wdata <= 8'h00;
      sel_d_reg  <= BMR_SEL_NONE;
      rd_d_reg   <= 1'b0;
    end else begin
      rom_addr   <= dec.offs;
      rom_rd     <= mem_req.rd && (dec.sel == BMR_SEL_ROM);
      mmio_addr  <= a;
      mmio_wr    <= dec.wr_ok && (dec.sel == BMR_SEL_MMIO);
      mmio_rd    <= mem_req.rd && (dec.sel == BMR_SEL_MMIO);
      mmio_wdata <= mem_req.wdata;
      sel_d_reg  <= dec.sel;
      rd_d_reg   <= mem_req.rd && acc;
    end
  end
  // Read data mux, unmapped reads give FF
  wire [7:0] rd_mux = (sel_d_reg == BMR_SEL_RAM) ? ram_rdata :
                      (sel_d_reg == BMR_SEL_ROM) ? rom_rdata :
                      (sel_d_reg == BMR_SEL_MMIO) ? mmio_rdata : 8'hFF;
  assign mem_rdata  = rd_mux;
  assign mem_rvalid = rd_d_reg;

  // ==========================================================
  // Core reset and restart
  logic map_d_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rst_n      <= 1'b0;
      core_restart    <= 1'b0;
      core_restart_pc <= `BMR_RESET_VECTOR;
      map_d_reg       <= 1'b0;
    end else begin
      // [R7] First fetch from zero, in boot ROM
      core_rst_n      <= 1'b1;
      map_d_reg       <= map_switch_bit_reg;
      // [R9] Map switch restarts at zero in RAM
      core_restart    <= map_switch_bit_reg && !map_d_reg;
      core_restart_pc <= `BMR_RESET_VECTOR;
    end
  end

  // ==========================================================
  // Pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      suspend_indicator   <= 1'b0;
      pullup_drive_pin_o  <= 1'b0;
      pullup_drive_pin_oe <= 1'b0;
      external_irq_one    <= 1'b0;
    end else begin
      // [R11] Suspend follows USB state
      suspend_indicator   <= usb_suspended;
      // [R10] Connect attaches to bus
      pullup_drive_pin_o  <= bus_connect_bit_reg;
      // [R17] Float until connect set
      pullup_drive_pin_oe <= bus_connect_bit_reg;
      // [R13] Pin 3.3 never feeds interrupt one
      external_irq_one    <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_map_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R15]
    map_switch_bit_reg |=> map_switch_bit_reg) else $error("map bit cleared");
  a_boot_rom_lo: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    (!map_switch_bit_reg && mem_req.code && mem_req.rd && a <= 16'h17FF)
    |=> rom_rd) else $error("boot ROM low not read");
  a_norm_no_rom: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    (map_switch_bit_reg && mem_req.code && mem_req.rd && a <= 16'h17FF)
    |=> !rom_rd) else $error("ROM seen low in normal mode");
  // Any write into the low window in normal mode must miss the RAM
  a_code_ro: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
    (map_switch_bit_reg && mem_req.wr && a <= 16'h1FFF) |-> !ram_we)
    else $error("code RAM written in normal mode");
  a_data_ram_wr: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    (!map_switch_bit_reg && !mem_req.code && mem_req.wr && a <= 16'h1FFF)
    |-> ram_we) else $error("boot data write lost");
  a_mmio_route: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    (!mem_req.code && mem_req.rd && a >= 16'hFD80) |=> mmio_rd)
    else $error("mmio read not routed");
  a_pullup_oe: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
    $rose(bus_connect_bit_reg) |=> pullup_drive_pin_oe) else $error("pullup not driven");
  a_restart_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
    $rose(map_switch_bit_reg) |=> core_restart ##1 !core_restart)
    else $error("restart pulse wrong");
  a_suspend_indicator_follow: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
    1'b1 |=> suspend_indicator == $past(usb_suspended)) else $error("suspend mismatch");
  c_switch: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(map_switch_bit_reg));
  c_connect: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(bus_connect_bit_reg));
  c_code_ram: cover property (@(posedge ref_clk) disable iff (!rst_n) code_ram && mem_req.rd);
endmodule

//--- testbench/bmr_far_model.sv
`timescale 1ns/10ps
// ==============================
// Far-side memory model: ROM and MMIO
module bmr_far_model (
  input  wire logic [15:0] rom_addr,
  input  wire logic        rom_rd,
  input  wire logic [15:0] mmio_addr,
  input  wire logic        mmio_rd,
  output logic      [7:0]  rom_rdata,
  output logic      [7:0]  mmio_rdata
);
  logic [7:0] rom_val;
  logic [7:0] mmio_val;
  // Contents follow the offset; idle buses show the inverse so stale data never match
  assign rom_val    = rom_addr[7:0] ^ rom_addr[15:8] ^ 8'hA5;
  assign mmio_val   = mmio_addr[7:0] ^ mmio_addr[15:8] ^ 8'h3C;
  assign rom_rdata  = rom_rd ? rom_val : ~rom_val;
  assign mmio_rdata = mmio_rd ? mmio_val : ~mmio_val;
endmodule

//--- testbench/test_boot_memory_remap.sv
`timescale 1ns/10ps
// ==============================
// Remap block bench
module test_boot_memory_remap;
  import bmr_pkg::*;
  typedef struct {logic m; logic c; logic [15:0] a; logic [7:0] e;} bmr_row_t;
  logic        ref_clk, nrst, reg_wr, reg_rd, usb_suspended, self_powered, port3_bit3;
  logic        mem_rvalid, rom_rd, mmio_wr, mmio_rd, suspend_indicator, core_rst_n;
  logic        pullup_drive_pin_o, pullup_drive_pin_oe, core_restart, external_irq_one;
  logic        mapped, rv;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, mem_rdata, rom_rdata, mmio_rdata, mmio_wdata, rd;
  logic [15:0] rom_addr, mmio_addr, core_restart_pc;
  bmr_req_t    mem_req;
  bmr_row_t    rows[13];
  int          fails, n_tests, i;

  bmr_top bmr_top_inst (.ref_clk, .nrst, .mem_req, .mem_rdata, .mem_rvalid, .rom_rdata,
    .rom_addr, .rom_rd, .mmio_addr, .mmio_wr, .mmio_rd, .mmio_wdata, .mmio_rdata, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .usb_suspended, .self_powered, .port3_bit3,
    .suspend_indicator, .pullup_drive_pin_o, .pullup_drive_pin_oe, .core_rst_n,
    .core_restart_pc, .core_restart, .external_irq_one);
  bmr_far_model bmr_far_model_inst (.rom_addr, .rom_rd, .mmio_addr, .mmio_rd, .rom_rdata,
    .mmio_rdata);

  // Compare and count
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Register port cycle, read data one cycle later
  task reg_acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Core memory cycle
  task mem_acc(input logic c, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    mem_req <= '{c, !w, w, a, d};
    @(posedge ref_clk);
    mem_req <= '{c, 1'b0, 1'b0, a, d};
    #1 rd = mem_rdata;
    rv = mem_rvalid;
  endtask
  function automatic logic [7:0] romv(input logic [15:0] o);
    return o[7:0] ^ o[15:8] ^ 8'hA5;
  endfunction

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Watchdog, about a hundred times the expected run
  initial begin
    #40000;
    fails++;
    end_sim;
  end

  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, usb_suspended, mapped} = '0;
    mem_req = '0;
    port3_bit3 = 1'b1;
    self_powered = 1'b1;
    fails = 0;
    n_tests = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reg_acc(0, 4'h0, 8'h00);
    check("map_ctl", rd, 8'h00);
    reg_acc(0, 4'h1, 8'h00);
    check("usb_ctl", rd, 8'h00);
    check("pullup_oe", pullup_drive_pin_oe, 0);
    check("irq_one", external_irq_one, 0);
    check("core_rst_n", core_rst_n, 1);
    $display("test reset done");
    // Load program RAM through data space
    mem_acc(0, 1, 16'h0000, 8'h5A);
    mem_acc(0, 1, 16'h1FFF, 8'hC3);
    rows = '{'{0, 1, 16'h0000, romv(0)}, '{0, 1, 16'h17FF, romv(16'h17FF)},
      '{0, 1, 16'h8000, romv(0)}, '{0, 1, 16'h97FF, romv(16'h17FF)}, '{0, 1, 16'h1800, 8'hFF},
      '{0, 0, 16'h0000, 8'h5A}, '{0, 0, 16'h1FFF, 8'hC3}, '{0, 0, 16'hFD80, 8'h41},
      '{1, 1, 16'h0000, 8'h5A}, '{1, 1, 16'h1FFF, 8'hC3}, '{1, 1, 16'h97FF, romv(16'h17FF)},
      '{1, 0, 16'h0000, 8'hFF}, '{1, 0, 16'hFFFF, 8'h3C}};
    for (i = 0; i < 13; i++) begin
      if (rows[i].m && !mapped) begin
        reg_acc(1, 4'h0, 8'h01);
        @(posedge ref_clk);
        #1 check("restart", core_restart, 1);
        check("restart_pc", core_restart_pc, 16'h0000);
        mapped = 1'b1;
      end
      mem_acc(rows[i].c, 0, rows[i].a, 8'h00);
      check("mem_rdata", rd, rows[i].e);
      check("mem_rvalid", rv, 1);
    end
    $display("test map rows done");
    // Clearing the map bit and writing code space have no effect
    reg_acc(1, 4'h0, 8'h00);
    reg_acc(0, 4'h0, 8'h00);
    check("map_hold", rd, 8'h01);
    mem_acc(1, 1, 16'h0000, 8'h77);
    check("rvalid_wr", rv, 0);
    mem_acc(0, 1, 16'h0000, 8'h66);
    mem_acc(1, 0, 16'h0000, 8'h00);
    check("code_ro", rd, 8'h5A);
    mem_acc(0, 1, 16'hFE00, 8'h3C);
    check("mmio_wr", mmio_wr, 1);
    check("mmio_addr", mmio_addr, 16'hFE00);
    check("mmio_wdata", mmio_wdata, 8'h3C);
    check("mmio_rd", mmio_rd, 0);
    $display("test protect done");
    // Attach, then an unmapped offset write leaves it alone
    reg_acc(1, 4'h1, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 check("pullup_oe", pullup_drive_pin_oe, 1);
    check("pullup_o", pullup_drive_pin_o, 1);
    reg_acc(1, 4'hF, 8'hFE);
    reg_acc(0, 4'h1, 8'h00);
    check("usb_ctl", rd, 8'h01);
    // Suspend indicator and status levels
    @(posedge ref_clk);
    usb_suspended <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check("suspend", suspend_indicator, 1);
    reg_acc(0, 4'h2, 8'h00);
    check("status", rd[2:0], 3'h7);
    @(posedge ref_clk);
    usb_suspended <= 1'b0;
    self_powered <= 1'b0;
    port3_bit3 <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check("suspend", suspend_indicator, 0);
    reg_acc(0, 4'h2, 8'h00);
    check("status", rd[2:0], 3'h0);
    check("irq_one", external_irq_one, 0);
    $display("test pins done");
    // Reset in mid-run returns to boot mode, detached
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check("core_rst_n", core_rst_n, 0);
    check("pullup_oe", pullup_drive_pin_oe, 0);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reg_acc(0, 4'h0, 8'h00);
    check("map_ctl", rd, 8'h00);
    mem_acc(1, 0, 16'h0000, 8'h00);
    check("first_fetch", rd, romv(0));
    check("rom_rd", rom_rd, 1);
    check("rom_addr", rom_addr, 16'h0000);
    $display("test mid reset done");
    end_sim;
  end
endmodule
